/* File: sreg_hint_defines.svh */
`ifndef SREG_HINT_DEFINES_SVH
`define SREG_HINT_DEFINES_SVH

// APB register byte offsets.
`define ADDR_CTRL 8'h00
`define ADDR_STATE 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0C

// Control register fields.
`define CTRL_PEND_EV_BIT 0
`define CTRL_DBG_EN_BIT 1
`define CTRL_RESET 2'h0

// State register fields.
`define STATE_EVENT_BIT 0
`define STATE_WAIT_EV_BIT 1
`define STATE_WAIT_INT_BIT 2
`define STATE_THR_LSB 8

// Interrupt status bits.
`define IRQ_W 4
`define IRQ_SVC_BIT 0
`define IRQ_WAKE_BIT 1
`define IRQ_DENY_BIT 2
`define IRQ_SEV_BIT 3
`define IRQ_RESET 4'h0

// Program status layout.
`define FLAG_LSB 27
`define FLAG_W 5
`define EXC_NUM_W 9
`define EXEC_BITS_MASK 32'h0700_FC00
`define CONTROL_W 2

`endif

/* File: sreg_hint_exec.sv */
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "sreg_hint_defines.svh"
module sreg_hint_exec
  import sreg_hint_pkg::*;
#(
  parameter int PRIO_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire exec_req_t req,
  output logic req_ready,
  output logic done,
  output logic [31:0] rd_data,
  output logic [`FLAG_W-1:0] flags,
  output logic [PRIO_W-1:0] base_priority_threshold,
  output logic interrupt_disable_mask,
  output logic fault_disable_mask,
  output logic [`CONTROL_W-1:0] control,
  output logic [31:0] main_sp,
  output logic [31:0] proc_sp,
  output logic sev_out,
  output logic svc_raise,
  output logic sleeping,
  output logic irq,
  input wire logic [`EXC_NUM_W-1:0] exc_number,
  input wire logic [31:0] exec_state_bits,
  input wire logic exc_unmasked,
  input wire logic exc_any,
  input wire logic exc_pending_new,
  input wire logic debug_req,
  input wire logic ext_event
);

  sleep_state_t state_q, state_d;
  logic [1:0] ctrl_q;
  logic [`IRQ_W-1:0] status_q, mask_q, ev_hits;
  logic event_q, done_q, sev_q, svc_q, ready_q, irq_q;
  logic [31:0] rd_q, prdata_q;
  logic pready_q, pslverr_q;
  logic sleeping_q;
  logic [`FLAG_W-1:0] flags_q;
  logic [PRIO_W-1:0] thr_q;
  logic pmask_q, fmask_q;
  logic [`CONTROL_W-1:0] control_q;
  logic [31:0] msp_q, psp_q;

  logic take, is_move_to, is_psr, wr_allowed, ev_set, wake_ev, wake_int, wake;
  logic apb_acc, apb_wr, mapped;
  logic [PRIO_W-1:0] src_prio;
  logic [31:0] psr_view;

  assign take = req.valid && ready_q;
  assign is_move_to = take && req.op == OP_MOVE_TO;
  assign is_psr = req.sreg inside {SR_APP, SR_APP_INT, SR_APP_EXEC, SR_PROG,
                                   SR_INT, SR_EXEC, SR_INT_EXEC};
  // Unprivileged code may only touch the status registers, and there only flags.
  assign wr_allowed = req.priv;
  assign src_prio = req.src[PRIO_W-1:0];
  assign ev_set = (take && req.op == OP_SEND_EVENT) || ext_event ||
                  (exc_pending_new && ctrl_q[`CTRL_PEND_EV_BIT]);
  assign wake_ev = exc_unmasked || (exc_pending_new && ctrl_q[`CTRL_PEND_EV_BIT]) ||
                   (debug_req && ctrl_q[`CTRL_DBG_EN_BIT]) || ext_event || event_q;
  // Debug requests wake from this sleep even with debug disabled.
  assign wake_int = exc_any || debug_req;
  assign wake = (state_q == ST_WAIT_EV && wake_ev) || (state_q == ST_WAIT_INT && wake_int);
  assign apb_acc = psel && penable && pready_q;
  assign apb_wr = apb_acc && pwrite;
  assign mapped = paddr inside {`ADDR_CTRL, `ADDR_STATE, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK};
  assign ev_hits = {sev_q, is_move_to && !req.priv && !is_psr, wake, svc_q};

  always_comb begin
    psr_view = 32'h0000_0000;
    if (req.sreg inside {SR_APP, SR_APP_INT, SR_APP_EXEC, SR_PROG}) begin
      psr_view[31:`FLAG_LSB] = flags_q;
    end
    if (req.sreg inside {SR_INT, SR_APP_INT, SR_INT_EXEC, SR_PROG}) begin
      psr_view[`EXC_NUM_W-1:0] = exc_number;
    end
    if (req.sreg inside {SR_EXEC, SR_APP_EXEC, SR_INT_EXEC, SR_PROG}) begin
      psr_view = psr_view | (exec_state_bits & `EXEC_BITS_MASK);
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (take && req.op == OP_WAIT_EVENT && !event_q) begin
          state_d = ST_WAIT_EV;
        end else if (take && req.op == OP_WAIT_INT) begin
          state_d = ST_WAIT_INT;
        end
      end
      ST_WAIT_EV, ST_WAIT_INT: begin
        if (wake) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
      ready_q <= 1'b0;
      sleeping_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= state_d == ST_RUN;
      // Registered from the next state so the sleep flag leaves a flop directly.
      sleeping_q <= state_d != ST_RUN;
    end
  end

  // Events that end a wait-for-event sleep are consumed by it rather than latched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_q <= 1'b0;
    end else if (state_q == ST_WAIT_EV) begin
      if (wake) begin
        event_q <= 1'b0;
      end
    end else if (ev_set) begin
      event_q <= 1'b1;
    end else if (take && req.op == OP_WAIT_EVENT) begin
      event_q <= 1'b0;
    end
  end

  // A no-op is acknowledged with no other effect.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      sev_q <= 1'b0;
      svc_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      done_q <= (take && !(req.op inside {OP_WAIT_EVENT, OP_WAIT_INT})) ||
                (take && req.op == OP_WAIT_EVENT && event_q) || wake;
      sev_q <= take && req.op == OP_SEND_EVENT;
      svc_q <= take && req.op == OP_SUPER_CALL;
      if (take && req.op == OP_MOVE_FROM) begin
        case (req.sreg)
          SR_MAIN_SP: rd_q <= msp_q;
          SR_PROC_SP: rd_q <= psp_q;
          SR_IRQ_MASK: rd_q <= {31'h0000_0000, pmask_q};
          SR_BASE_PRI, SR_BASE_RAISE: rd_q <= 32'(thr_q);
          SR_FAULT_MASK: rd_q <= {31'h0000_0000, fmask_q};
          SR_CONTROL: rd_q <= {30'h0000_0000, control_q};
          default: rd_q <= psr_view;
        endcase
      end
    end
  end

  // Flags move only on a move-to of a status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else if (is_move_to && is_psr) begin
      flags_q <= req.src[31:`FLAG_LSB];
    end
  end

  // Unprivileged writes to other names are dropped without a fault.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q <= '0;
      pmask_q <= 1'b0;
      fmask_q <= 1'b0;
      control_q <= '0;
      msp_q <= 32'h0000_0000;
      psp_q <= 32'h0000_0000;
    end else if (is_move_to && wr_allowed) begin
      case (req.sreg)
        SR_MAIN_SP: msp_q <= req.src;
        SR_PROC_SP: psp_q <= req.src;
        SR_IRQ_MASK: pmask_q <= req.src[0];
        SR_BASE_PRI: thr_q <= src_prio;
        SR_BASE_RAISE: begin
          if (src_prio != '0 && (thr_q == '0 || src_prio < thr_q)) begin
            thr_q <= src_prio;
          end
        end
        SR_FAULT_MASK: fmask_q <= req.src[0];
        SR_CONTROL: control_q <= req.src[`CONTROL_W-1:0];
        default: thr_q <= thr_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      prdata_q <= 32'h0000_0000;
      if (psel && penable && !pready_q && !pwrite) begin
        case (paddr)
          `ADDR_CTRL: prdata_q <= {30'h0000_0000, ctrl_q};
          `ADDR_STATE: begin
            prdata_q[`STATE_EVENT_BIT] <= event_q;
            prdata_q[`STATE_WAIT_EV_BIT] <= state_q == ST_WAIT_EV;
            prdata_q[`STATE_WAIT_INT_BIT] <= state_q == ST_WAIT_INT;
            prdata_q[`STATE_THR_LSB +: PRIO_W] <= thr_q;
          end
          `ADDR_IRQ_STATUS: prdata_q <= 32'(status_q);
          `ADDR_IRQ_MASK: prdata_q <= 32'(mask_q);
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // New events win over a write-one-to-clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      mask_q <= `IRQ_RESET;
      status_q <= `IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == `ADDR_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end
      if (apb_wr && paddr == `ADDR_IRQ_MASK) begin
        mask_q <= pwdata[`IRQ_W-1:0];
      end
      if (apb_wr && paddr == `ADDR_IRQ_STATUS) begin
        status_q <= (status_q & ~pwdata[`IRQ_W-1:0]) | ev_hits;
      end else begin
        status_q <= status_q | ev_hits;
      end
      irq_q <= |(status_q & mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign req_ready = ready_q;
  assign done = done_q;
  assign rd_data = rd_q;
  assign flags = flags_q;
  assign base_priority_threshold = thr_q;
  assign interrupt_disable_mask = pmask_q;
  assign fault_disable_mask = fmask_q;
  assign control = control_q;
  assign main_sp = msp_q;
  assign proc_sp = psp_q;
  assign sev_out = sev_q;
  assign svc_raise = svc_q;
  assign sleeping = sleeping_q;
  assign irq = irq_q;

  a_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (take && req.op != OP_MOVE_TO) |=> flags_q == $past(flags_q))
    else $error("flags changed on a non-writing instruction");
  a_flags_load: assert property (@(posedge pclk) disable iff (!presetn)
    (is_move_to && is_psr) |=> flags_q == $past(req.src[31:27]))
    else $error("flags not loaded from source");
  a_raise_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (is_move_to && req.sreg == SR_BASE_RAISE &&
     (src_prio == '0 || (thr_q != '0 && src_prio >= thr_q))) |=> $stable(thr_q))
    else $error("raise-only write lowered or cleared threshold");
  a_raise_take: assert property (@(posedge pclk) disable iff (!presetn)
    (is_move_to && req.priv && req.sreg == SR_BASE_RAISE && src_prio != '0 &&
     (thr_q == '0 || src_prio < thr_q)) |=> thr_q == $past(src_prio))
    else $error("raise-only write not taken");
  a_unpriv_deny: assert property (@(posedge pclk) disable iff (!presetn)
    (is_move_to && !req.priv && !is_psr) |=> $stable(thr_q) && $stable(msp_q) &&
    $stable(psp_q) && $stable(pmask_q) && $stable(control_q) && done_q)
    else $error("unprivileged write changed a register");
  a_deny_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (is_move_to && !req.priv && !is_psr) |=> status_q[`IRQ_DENY_BIT])
    else $error("denied write not flagged");
  a_alias_read: assert property (@(posedge pclk) disable iff (!presetn)
    (take && req.op == OP_MOVE_FROM && req.sreg == SR_BASE_RAISE) |=>
    rd_q == 32'($past(thr_q)))
    else $error("raise-only read differs from threshold");
  a_sev_event: assert property (@(posedge pclk) disable iff (!presetn)
    (take && req.op == OP_SEND_EVENT) |=> sev_q && event_q && !svc_q)
    else $error("send-event did not pulse and set event");
  // A second supervisor call taken at once may legally keep the pulse high.
  a_svc_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (take && req.op == OP_SUPER_CALL) |=> svc_q && done_q ##1
    (!svc_q || $past(take && req.op == OP_SUPER_CALL)))
    else $error("supervisor call not raised for one cycle");
  a_nop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (take && req.op == OP_NOP) |=> done_q && !sev_q && !svc_q && $stable(flags_q))
    else $error("no-op had an effect");
  a_wfe_skip: assert property (@(posedge pclk) disable iff (!presetn)
    (take && req.op == OP_WAIT_EVENT && event_q && !ev_set) |=>
    done_q && !event_q && state_q == ST_RUN)
    else $error("wait-for-event with event set did not continue");
  a_wfe_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    (take && req.op == OP_WAIT_EVENT && !event_q) |=> state_q == ST_WAIT_EV && !done_q)
    else $error("wait-for-event did not suspend");
  a_wfe_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_WAIT_EV && (exc_unmasked || ext_event ||
     (exc_pending_new && ctrl_q[`CTRL_PEND_EV_BIT]) ||
     (debug_req && ctrl_q[`CTRL_DBG_EN_BIT]))) |=> state_q == ST_RUN && done_q && !event_q)
    else $error("wait-for-event did not wake");
  a_wfe_stay: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_WAIT_EV && !exc_unmasked && !ext_event && !event_q &&
     !(exc_pending_new && ctrl_q[`CTRL_PEND_EV_BIT]) &&
     !(debug_req && ctrl_q[`CTRL_DBG_EN_BIT])) |=> state_q == ST_WAIT_EV && !done_q)
    else $error("wait-for-event woke without a cause");
  a_wfi_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    (take && req.op == OP_WAIT_INT) |=> state_q == ST_WAIT_INT && !done_q && !ready_q)
    else $error("wait-for-interrupt did not suspend");
  a_wfi_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_WAIT_INT && (exc_any || debug_req)) |=> state_q == ST_RUN && done_q)
    else $error("wait-for-interrupt did not wake");
  a_wfi_stay: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_WAIT_INT && !exc_any && !debug_req) |=> state_q == ST_WAIT_INT && !done_q)
    else $error("wait-for-interrupt woke without a cause");
  a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_hits != '0) |=> (status_q & $past(ev_hits)) == $past(ev_hits))
    else $error("interrupt event lost against a clear");

endmodule : sreg_hint_exec

/* File: sreg_hint_pkg.sv */
package sreg_hint_pkg;

  typedef enum logic [2:0] {
    OP_MOVE_FROM = 3'h0,
    OP_MOVE_TO = 3'h1,
    OP_NOP = 3'h2,
    OP_SEND_EVENT = 3'h3,
    OP_SUPER_CALL = 3'h4,
    OP_WAIT_EVENT = 3'h5,
    OP_WAIT_INT = 3'h6
  } op_t;

  typedef enum logic [4:0] {
    SR_APP = 5'h00,
    SR_APP_INT = 5'h01,
    SR_APP_EXEC = 5'h02,
    SR_PROG = 5'h03,
    SR_INT = 5'h05,
    SR_EXEC = 5'h06,
    SR_INT_EXEC = 5'h07,
    SR_MAIN_SP = 5'h08,
    SR_PROC_SP = 5'h09,
    SR_IRQ_MASK = 5'h10,
    SR_BASE_PRI = 5'h11,
    SR_BASE_RAISE = 5'h12,
    SR_FAULT_MASK = 5'h13,
    SR_CONTROL = 5'h14
  } sreg_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_WAIT_EV = 3'b010,
    ST_WAIT_INT = 3'b100
  } sleep_state_t;

  typedef struct packed {
    logic valid;
    op_t op;
    sreg_t sreg;
    logic priv;
    logic [31:0] src;
  } exec_req_t;

endpackage : sreg_hint_pkg

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import sreg_hint_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data, main_sp, proc_sp, xbits, rd, r;
  logic pready, pslverr, req_ready, done, imask, fmask, sev_out, svc_raise, sleeping, irq;
  logic eu, ea, ep, dr, ee, slp, sv, sc, er;
  logic [4:0] flags, fl, wake_cmd = 5'h00;
  logic [7:0] thr, et;
  logic [1:0] control;
  logic [8:0] xnum;
  exec_req_t req = '0;
  int num_errors = 0, tests_run = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  sreg_hint_exec #(.PRIO_W(8)) i_sreg_hint_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req(req), .req_ready(req_ready), .done(done),
    .rd_data(rd_data), .flags(flags), .base_priority_threshold(thr),
    .interrupt_disable_mask(imask), .fault_disable_mask(fmask), .control(control),
    .main_sp(main_sp), .proc_sp(proc_sp), .sev_out(sev_out), .svc_raise(svc_raise),
    .sleeping(sleeping), .irq(irq), .exc_number(xnum), .exec_state_bits(xbits),
    .exc_unmasked(eu), .exc_any(ea), .exc_pending_new(ep), .debug_req(dr), .ext_event(ee));
  wake_source i_wake_source (.pclk(pclk), .presetn(presetn), .wake_cmd(wake_cmd),
    .exc_unmasked(eu), .exc_any(ea), .exc_pending_new(ep), .debug_req(dr), .ext_event(ee),
    .exc_number(xnum), .exec_state_bits(xbits));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] raise_thr(input logic [7:0] t, input logic [7:0] s);
    return (s != 8'h00 && (t == 8'h00 || s < t)) ? s : t;
  endfunction : raise_thr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    // One idle edge keeps the release of the last access apart from this setup.
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic exec(input op_t op, input sreg_t s, input logic pv, input logic [31:0] src,
                      input logic [4:0] wk);
    int n;
    req <= '{1'b1, op, s, pv, src};
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req.valid <= 1'b0;
    @(posedge pclk);
    {slp, sv, sc} = {sleeping, sev_out, svc_raise};
    if (wk != 5'h00) wake_cmd <= wk;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(posedge pclk);
      wake_cmd <= 5'h00;
      n++;
    end
    chk({31'h0, done}, 32'h1, "instruction completion");
  endtask : exec
  task automatic results;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    r = 32'h6266_cbc2;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[0], 32'h0, "event bit after reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped address error");
    apb(1'b1, 8'h0C, 32'h0000_000F);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0000_000F, "mask read back");
    fl = 5'h00;
    for (int i = 0; i < 12; i++) begin
      r = lfsr(r);
      exec(i % 2 ? OP_MOVE_TO : OP_MOVE_FROM, i % 3 ? SR_APP : SR_PROG, r[3], r, 5'h0);
      if (i % 2) begin
        chk(flags, r[31:27], "flags from source");
        fl = r[31:27];
      end else begin
        chk({flags, rd_data[31:27]}, {fl, fl}, "status read keeps flags");
      end
    end
    chk(control, 2'h0, "status write leaves control");
    r = lfsr(r);
    exec(OP_MOVE_TO, SR_MAIN_SP, 1'b1, r, 5'h0);
    exec(OP_MOVE_TO, SR_PROC_SP, 1'b1, ~r, 5'h0);
    exec(OP_MOVE_TO, SR_FAULT_MASK, 1'b1, 32'h0000_0001, 5'h0);
    exec(OP_MOVE_TO, SR_CONTROL, 1'b1, 32'h0000_0003, 5'h0);
    chk(main_sp, r, "privileged main stack write");
    chk(proc_sp, ~r, "privileged process stack write");
    chk({fmask, control}, 3'h7, "privileged mask and control write");
    exec(OP_MOVE_FROM, SR_PROC_SP, 1'b0, 32'h0, 5'h0);
    chk(rd_data, ~r, "stack pointer read back");
    exec(OP_MOVE_TO, SR_BASE_PRI, 1'b1, 32'h0000_0040, 5'h0);
    et = 8'h40;
    for (int k = 0; k < 5; k++) begin
      r = {24'h0, k == 0 ? 8'h00 : k == 1 ? 8'h50 : k == 2 ? 8'h40 : k == 3 ? 8'h20 : 8'h30};
      exec(OP_MOVE_TO, SR_BASE_RAISE, 1'b1, r, 5'h0);
      et = raise_thr(et, r[7:0]);
      chk(thr, et, "raise-only threshold");
      exec(OP_MOVE_FROM, SR_BASE_RAISE, 1'b0, 32'h0, 5'h0);
      chk(rd_data[7:0], et, "raise-only alias read");
    end
    exec(OP_MOVE_TO, SR_BASE_PRI, 1'b1, 32'h0, 5'h0);
    r = lfsr(r);
    et = raise_thr(8'h00, r[7:0]);
    exec(OP_MOVE_TO, SR_BASE_RAISE, 1'b1, r, 5'h0);
    chk(thr, et, "raise-only from zero threshold");
    exec(OP_MOVE_TO, SR_BASE_PRI, 1'b0, 32'h0000_0011, 5'h0);
    exec(OP_MOVE_TO, SR_IRQ_MASK, 1'b0, 32'h0000_0001, 5'h0);
    exec(OP_MOVE_TO, SR_CONTROL, 1'b0, 32'h0, 5'h0);
    chk({control, imask, thr}, {2'h3, 1'b0, et}, "unprivileged write dropped");
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[2], 32'h1, "denied write status");
    exec(OP_NOP, SR_APP, 1'b1, 32'hFFFF_FFFF, 5'h0);
    chk(flags, fl, "no-op leaves flags");
    exec(OP_SUPER_CALL, SR_APP, 1'b0, 32'h0000_00FF, 5'h0);
    chk({sc, flags}, {1'b1, fl}, "supervisor call raised");
    exec(OP_SEND_EVENT, SR_APP, 1'b0, 32'h0, 5'h0);
    chk({sv, flags}, {1'b1, fl}, "send-event pulse");
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[0], 32'h1, "event bit set");
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "interrupt raised");
    apb(1'b1, 8'h08, 32'h0000_000F);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "interrupt cleared");
    exec(OP_WAIT_EVENT, SR_APP, 1'b0, 32'h0, 5'h0);
    chk({31'h0, slp}, 32'h0, "wait with event set continues");
    exec(OP_WAIT_EVENT, SR_APP, 1'b0, 32'h0, 5'h10);
    chk({slp, flags}, {1'b1, fl}, "wait-for-event sleeps then wakes");
    exec(OP_WAIT_EVENT, SR_APP, 1'b0, 32'h0, 5'h01);
    chk({31'h0, slp}, 32'h1, "unmasked exception wakes");
    exec(OP_WAIT_INT, SR_APP, 1'b0, 32'h0, 5'h08);
    chk({slp, flags}, {1'b1, fl}, "debug request wakes interrupt wait");
    exec(OP_WAIT_INT, SR_APP, 1'b0, 32'h0, 5'h02);
    chk({31'h0, slp}, 32'h1, "exception wakes interrupt wait");
    apb(1'b1, 8'h00, 32'h0000_0003);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0003, "control read back");
    exec(OP_WAIT_EVENT, SR_APP, 1'b0, 32'h0, 5'h04);
    chk({31'h0, slp}, 32'h1, "pending exception wakes when enabled");
    exec(OP_WAIT_EVENT, SR_APP, 1'b0, 32'h0, 5'h08);
    chk({31'h0, slp}, 32'h1, "debug request wakes when enabled");
    results();
  end
endmodule : tb_top

/* File: wake_source.sv */
`timescale 1ns/10ps
// Stands in for the exception controller, debug logic and event sources.
module wake_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] wake_cmd,
  output logic exc_unmasked,
  output logic exc_any,
  output logic exc_pending_new,
  output logic debug_req,
  output logic ext_event,
  output logic [8:0] exc_number,
  output logic [31:0] exec_state_bits
);
  logic [31:0] cnt_q;
  // Status views change every cycle so a stale read cannot pass by luck.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0101_0405;
    end
  end
  assign exc_number = cnt_q[8:0];
  assign exec_state_bits = cnt_q;
  // Each commanded cause lasts exactly one cycle, as a real pulse would.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ext_event, debug_req, exc_pending_new, exc_any, exc_unmasked} <= 5'h0;
    end else begin
      {ext_event, debug_req, exc_pending_new, exc_any, exc_unmasked} <= wake_cmd;
    end
  end
endmodule : wake_source
